// [include/pin_pkg.sv]
// constants, carriers and helpers shared by the secret-code command handler
// assumes one card clock domain; all widths are fixed by the command framing
package pin_pkg;

  // ----------------------------------------------------------------------
  // register map of the plain software port (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] A_DISABLE  = 8'h00;
  localparam logic [7:0] A_UNBLOCK  = 8'h04;
  localparam logic [7:0] A_CODE_LO  = 8'h08;
  localparam logic [7:0] A_CODE_HI  = 8'h0C;
  localparam logic [7:0] A_BLOCKED  = 8'h10;
  localparam logic [7:0] A_VERIFIED = 8'h14;
  localparam logic [7:0] A_RETRY    = 8'h18;

  // ----------------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [1:0]  RETRY_INIT  = 2'h3;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;
  localparam logic [63:0] CODE_ERASED = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------------
  // command field coding
  // ----------------------------------------------------------------------
  localparam logic [7:0] P1_ZERO       = 8'h00;
  localparam logic [7:0] P2_RFU_MASK   = 8'h60;
  localparam logic [7:0] P2_REF_MASK   = 8'h1F;
  localparam int         P2_SPECIFIC   = 7;
  localparam logic [7:0] LC_VERIFY     = 8'h08;
  localparam logic [7:0] LC_CHANGE     = 8'h10;

  // ----------------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------------
  localparam logic [15:0] SW_NONE       = 16'h0000;
  localparam logic [15:0] SW_OK         = 16'h9000;
  localparam logic [15:0] SW_RETRY_BASE = 16'h63C0;
  localparam logic [15:0] SW_BLOCKED    = 16'h6983;
  localparam logic [15:0] SW_COND       = 16'h6985;
  localparam logic [15:0] SW_WRONG_LEN  = 16'h6700;
  localparam logic [15:0] SW_WRONG_P1P2 = 16'h6B00;
  localparam logic [15:0] SW_NOT_FOUND  = 16'h6A88;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic         isChange;
    logic [7:0]   p1;
    logic [7:0]   p2;
    logic         lcPresent;
    logic [7:0]   lc;
    logic [127:0] data;       // byte 1 in [127:120]; old code [127:64], new [63:0]
  } apdu_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] sw;
  } rsp_s;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } regreq_s;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_LOOK = 2'b10
  } state_e;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] swRetry(input logic [1:0] cnt);
    return {SW_RETRY_BASE[15:4], 2'b00, cnt};
  endfunction

endpackage

// [rtl/pin_nv_store.sv]
// nonvolatile store of code, attempts counter and blocked flag per reference
// assumes the cell technology keeps contents over card reset; nvErase formats it
`timescale 1ns/100ps
module pin_nv_store #(
  parameter int NENT = 8,
  parameter int IW   = 3
) (
  // clock and format
  input  wire logic              mclk,
  input  wire logic              nvErase,
  // write port
  input  wire logic              we,
  input  wire logic [IW-1:0]     wIdx,
  input  wire logic [1:0]        wRetry,
  input  wire logic              wBlocked,
  input  wire logic              wCodeEn,
  input  wire logic [63:0]       wCode,
  // read port
  input  wire logic              rLoad,
  input  wire logic [IW-1:0]     rIdx,
  output logic      [63:0]       rdCode,
  output logic      [2*NENT-1:0] retryVec,
  output logic      [NENT-1:0]   blockedVec
);
  import pin_pkg::*;

  logic [63:0]   codeMem [NENT];
  logic [1:0]    retryMem [NENT];
  logic [NENT-1:0] blockedMem;
  logic [IW-1:0] rIdx_ff;

  // ----------------------------------------------------------------------
  // storage: no sys_rst on purpose, counts must survive card sessions
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (nvErase) begin
      for (int i = 0; i < NENT; i++) begin
        codeMem[i]  <= CODE_ERASED;
        retryMem[i] <= RETRY_INIT;
      end
      blockedMem <= '0;
    end else if (we) begin
      retryMem[wIdx]   <= wRetry;
      blockedMem[wIdx] <= wBlocked;
      if (wCodeEn) begin
        codeMem[wIdx] <= wCode;
      end
    end
  end

  // registered address, array read after it so a write is seen at once
  always_ff @(posedge mclk) begin
    if (rLoad) begin
      rIdx_ff <= rIdx;
    end
  end

  assign rdCode     = codeMem[rIdx_ff];
  assign blockedVec = blockedMem;

  always_comb begin
    retryVec = '0;
    for (int i = 0; i < NENT; i++) begin
      retryVec[2*i +: 2] = retryMem[i];
    end
  end

endmodule

// [rtl/pin_verify_change_handler.sv]
// card-side handler of the secret-code verify and change commands
// assumes the terminal holds cmdValid only while busy is low and the store is formatted
`timescale 1ns/100ps
module pin_verify_change_handler #(
  parameter int REFS = 4,
  parameter int IW   = $clog2(REFS) + 1
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  // store format request
  input  wire logic            nvErase,
  // command and answer
  input  wire pin_pkg::apdu_s  cmd,
  input  wire logic            cmdValid,
  output logic                 busy,
  output pin_pkg::rsp_s        rsp,
  // software port
  input  wire pin_pkg::regreq_s busReq,
  output logic [31:0]          rdata,
  // file access check
  input  wire logic [IW-1:0]   accessIdx,
  output logic                 accessGranted
);
  import pin_pkg::*;

  localparam int NENT = 2 * REFS;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  state_e          state_ff;
  apdu_s           cmd_ff;
  logic [IW-1:0]   idx_ff;
  logic [15:0]     errSw_ff;
  logic            opUnblock_ff;
  logic            unblockPend_ff;
  logic [IW-1:0]   unblockIdx_ff;
  logic [63:0]     staged_ff;
  logic [NENT-1:0] disable_ff;
  logic [NENT-1:0] verified_ff;
  logic            busy_ff;
  rsp_s            rsp_ff;
  logic [31:0]     rdata_ff;
  logic            access_ff;

  logic [63:0]       nvCode;
  logic [2*NENT-1:0] retryVec;
  logic [NENT-1:0]   blockedVec;

  logic            take;
  logic [15:0]     nxt_errSw;
  logic [IW-1:0]   nxt_idx;
  logic [1:0]      cnt;
  logic            blk;
  logic            dis;
  logic            isQuery;
  logic            match;
  logic            inLook;
  logic            evQuery;
  logic            evBlocked;
  logic            evDisabled;
  logic            evMatch;
  logic            evMiss;
  logic [1:0]      cntDec;
  logic            nvWe;
  logic [1:0]      nvRetry;
  logic            nvBlocked;
  logic            nvCodeEn;
  logic [63:0]     nvWCode;
  logic [IW-1:0]   nvIdx;
  logic            nxt_verifySet;
  logic            nxt_verifyClr;
  logic            regUnblock;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [1:0] cntOf(input logic [2*NENT-1:0] v, input logic [IW-1:0] i);
    return v[2*i +: 2];
  endfunction

  function automatic logic [15:0] checkFields(input apdu_s c);
    logic [4:0] refNum;
    refNum = c.p2[4:0];
    if (c.p1 != P1_ZERO || (c.p2 & P2_RFU_MASK) != 8'h00 || (c.p2 & P2_REF_MASK) == 8'h00) begin
      return SW_WRONG_P1P2;
    end
    if (c.isChange && !(c.lcPresent && c.lc == LC_CHANGE)) begin
      return SW_WRONG_LEN;
    end
    if (!c.isChange && c.lcPresent && c.lc != LC_VERIFY) begin
      return SW_WRONG_LEN;
    end
    if (refNum > 5'(REFS)) begin
      return SW_NOT_FOUND;
    end
    return SW_NONE;
  endfunction

  // ----------------------------------------------------------------------
  // command intake and decode
  // ----------------------------------------------------------------------
  logic [4:0] refM1;
  assign take      = (state_ff == S_IDLE) && cmdValid && !busy_ff && !unblockPend_ff;
  assign nxt_errSw = checkFields(cmd);
  assign refM1     = cmd.p2[4:0] - 5'h01;
  assign nxt_idx   = {cmd.p2[P2_SPECIFIC], refM1[IW-2:0]};
  assign regUnblock = busReq.wr && busReq.addr == A_UNBLOCK;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff     <= S_IDLE;
      opUnblock_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        S_IDLE: begin
          if (unblockPend_ff) begin
            state_ff     <= S_LOOK;
            opUnblock_ff <= 1'b1;
          end else if (take) begin
            state_ff     <= S_LOOK;
            opUnblock_ff <= 1'b0;
          end
        end
        S_LOOK: begin
          state_ff     <= S_IDLE;
          opUnblock_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_ff   <= '0;
      idx_ff   <= '0;
      errSw_ff <= SW_NONE;
    end else if (state_ff == S_IDLE && unblockPend_ff) begin
      idx_ff   <= unblockIdx_ff;
      errSw_ff <= SW_NONE;
    end else if (take) begin
      cmd_ff   <= cmd;
      idx_ff   <= nxt_idx;
      errSw_ff <= nxt_errSw;
    end
  end

  // busy covers the evaluation cycle and any queued maintenance unblock
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= take || regUnblock || (state_ff == S_IDLE && unblockPend_ff)
                 || (unblockPend_ff && state_ff == S_LOOK);
    end
  end

  // ----------------------------------------------------------------------
  // evaluation: the store is shared, so every channel sees one truth
  // ----------------------------------------------------------------------
  assign cnt     = cntOf(retryVec, idx_ff);
  assign blk     = blockedVec[idx_ff];
  assign dis     = disable_ff[idx_ff];
  assign isQuery = !cmd_ff.isChange && !cmd_ff.lcPresent;
  assign match   = (nvCode == cmd_ff.data[127:64]);
  assign inLook  = (state_ff == S_LOOK) && !opUnblock_ff;
  assign cntDec  = cnt - 2'h1;

  assign evQuery    = inLook && errSw_ff == SW_NONE && isQuery;
  assign evBlocked  = inLook && errSw_ff == SW_NONE && !isQuery && blk;
  assign evDisabled = inLook && errSw_ff == SW_NONE && !isQuery && !blk && dis;
  assign evMatch    = inLook && errSw_ff == SW_NONE && !isQuery && !blk && !dis && match;
  assign evMiss     = inLook && errSw_ff == SW_NONE && !isQuery && !blk && !dis && !match;

  always_comb begin
    nvWe      = 1'b0;
    nvRetry   = cnt;
    nvBlocked = blk;
    nvCodeEn  = 1'b0;
    nvWCode   = cmd_ff.data[63:0];
    nvIdx     = idx_ff;
    if (state_ff == S_LOOK && opUnblock_ff) begin
      nvWe      = 1'b1;
      nvRetry   = RETRY_INIT;
      nvBlocked = 1'b0;
      nvCodeEn  = 1'b1;
      nvWCode   = staged_ff;
    end else if (evMatch) begin
      nvWe     = 1'b1;
      nvRetry  = RETRY_INIT;
      nvCodeEn = cmd_ff.isChange;
    end else if (evMiss) begin
      nvWe      = 1'b1;
      nvRetry   = cntDec;
      nvBlocked = (cntDec == 2'h0);
    end
  end

  pin_nv_store #(
    .NENT (NENT),
    .IW   (IW)
  ) u_store (
    .mclk       (mclk),
    .nvErase    (nvErase),
    .we         (nvWe),
    .wIdx       (nvIdx),
    .wRetry     (nvRetry),
    .wBlocked   (nvBlocked),
    .wCodeEn    (nvCodeEn),
    .wCode      (nvWCode),
    .rLoad      (take || (state_ff == S_IDLE && unblockPend_ff)),
    .rIdx       ((state_ff == S_IDLE && unblockPend_ff) ? unblockIdx_ff : nxt_idx),
    .rdCode     (nvCode),
    .retryVec   (retryVec),
    .blockedVec (blockedVec)
  );

  // ----------------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= inLook;
      if (inLook) begin
        if (errSw_ff != SW_NONE) begin
          rsp_ff.sw <= errSw_ff;
        end else if (evQuery) begin
          rsp_ff.sw <= blk ? SW_BLOCKED : swRetry(cnt);
        end else if (evBlocked) begin
          rsp_ff.sw <= SW_BLOCKED;
        end else if (evDisabled) begin
          rsp_ff.sw <= SW_COND;
        end else if (evMatch) begin
          rsp_ff.sw <= SW_OK;
        end else begin
          rsp_ff.sw <= swRetry(cntDec);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // security state, volatile, one flag per reference for all channels
  // ----------------------------------------------------------------------
  assign nxt_verifySet = evMatch;
  assign nxt_verifyClr = evMiss;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      verified_ff <= '0;
    end else if (nxt_verifySet) begin
      verified_ff[idx_ff] <= 1'b1;
    end else if (nxt_verifyClr) begin
      verified_ff[idx_ff] <= 1'b0;
    end
  end

  // blocked and disabled grants, blocked and enabled never does
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      access_ff <= 1'b0;
    end else begin
      access_ff <= disable_ff[accessIdx] ||
                   (verified_ff[accessIdx] && !blockedVec[accessIdx]);
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      disable_ff <= '0;
      staged_ff  <= CODE_ERASED;
    end else if (busReq.wr) begin
      if (busReq.addr == A_DISABLE) begin
        disable_ff <= busReq.wdata[NENT-1:0];
      end
      if (busReq.addr == A_CODE_LO) begin
        staged_ff[31:0] <= busReq.wdata;
      end
      if (busReq.addr == A_CODE_HI) begin
        staged_ff[63:32] <= busReq.wdata;
      end
    end
  end

  // a new unblock request wins over the pending one being served
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      unblockPend_ff <= 1'b0;
      unblockIdx_ff  <= '0;
    end else if (regUnblock) begin
      unblockPend_ff <= 1'b1;
      unblockIdx_ff  <= busReq.wdata[IW-1:0];
    end else if (state_ff == S_IDLE && unblockPend_ff) begin
      unblockPend_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_ff <= RDATA_RST;
    end else if (busReq.rd) begin
      unique case (busReq.addr)
        A_DISABLE:  rdata_ff <= 32'(disable_ff);
        A_BLOCKED:  rdata_ff <= 32'(blockedVec);
        A_VERIFIED: rdata_ff <= 32'(verified_ff);
        A_RETRY:    rdata_ff <= 32'(retryVec);
        default:    rdata_ff <= RDATA_RST;
      endcase
    end else begin
      rdata_ff <= RDATA_RST;
    end
  end

  assign busy          = busy_ff;
  assign rsp           = rsp_ff;
  assign rdata         = rdata_ff;
  assign accessGranted = access_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_match_restore: assert property (@(posedge mclk) disable iff (sys_rst)
    evMatch |=> cntOf(retryVec, idx_ff) == RETRY_INIT && rsp.sw == SW_OK)
    else $error("counter not restored after correct code");

  a_miss_decrement: assert property (@(posedge mclk) disable iff (sys_rst)
    evMiss |=> cntOf(retryVec, idx_ff) == $past(cnt) - 2'h1)
    else $error("counter not decremented after wrong code");

  a_miss_status: assert property (@(posedge mclk) disable iff (sys_rst)
    evMiss && cnt == 2'h3 |=> rsp.valid && rsp.sw == 16'h63C2)
    else $error("first miss status wrong");

  a_third_block: assert property (@(posedge mclk) disable iff (sys_rst)
    evMiss && cnt == 2'h1 |=> blockedVec[idx_ff] && rsp.sw == 16'h63C0)
    else $error("third miss did not block");

  a_blocked_refuse: assert property (@(posedge mclk) disable iff (sys_rst)
    evBlocked |=> rsp.sw == SW_BLOCKED && $stable(retryVec) && !verified_ff[idx_ff])
    else $error("blocked reference was compared");

  a_disabled_skip: assert property (@(posedge mclk) disable iff (sys_rst)
    evDisabled |=> rsp.sw == SW_COND && $stable(retryVec))
    else $error("disabled reference was compared");

  a_query_answer: assert property (@(posedge mclk) disable iff (sys_rst)
    evQuery && !blk |=> rsp.sw == swRetry($past(cnt)) && $stable(retryVec))
    else $error("query status wrong");

  a_change_store: assert property (@(posedge mclk) disable iff (sys_rst)
    evMatch && cmd_ff.isChange |=> nvCode == $past(cmd_ff.data[63:0]))
    else $error("new code not stored");

  a_bad_fields: assert property (@(posedge mclk) disable iff (sys_rst)
    inLook && errSw_ff != SW_NONE |=> $stable(retryVec) && rsp.sw == $past(errSw_ff))
    else $error("refused command touched a counter");

  a_access_blocked: assert property (@(posedge mclk) disable iff (sys_rst)
    blockedVec[accessIdx] && !disable_ff[accessIdx] |=> !accessGranted)
    else $error("blocked reference granted access");

  a_resp_timing: assert property (@(posedge mclk) disable iff (sys_rst)
    take |=> busy ##1 rsp.valid)
    else $error("answer not one cycle after evaluation");

endmodule

// [verification/pin_terminal.sv]
// terminal model: frames verify and change commands and collects the status word
// assumes the handler answers within a few cycles of taking a command
`timescale 1ns/100ps
module pin_terminal (
  // clock and answer
  input  wire logic           mclk,
  input  wire logic           busy,
  input  wire pin_pkg::rsp_s  rsp,
  // command
  output pin_pkg::apdu_s      cmd,
  output logic                cmdValid
);
  import pin_pkg::*;

  initial begin
    cmd = '0;
    cmdValid = 1'b0;
  end

  // ----------------------------------------------------------------------
  // one command, one answer
  // ----------------------------------------------------------------------
  // waits out busy first, so a queued unblock never swallows the command
  task automatic send(input logic chg, input logic [7:0] p1, input logic [7:0] p2,
                      input logic lcp, input logic [7:0] lc, input logic [127:0] d,
                      output logic [15:0] sw);
    int n;
    n = 0;
    sw = 16'hxxxx;
    #1;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    cmd <= '{chg, p1, p2, lcp, lc, d};
    cmdValid <= 1'b1;
    @(posedge mclk);
    cmdValid <= 1'b0;
    cmd.data <= ~d; // released data no longer shows the code
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      #1;
      if (rsp.valid === 1'b1) begin
        sw = rsp.sw;
        break;
      end
    end
  endtask
endmodule

// [verification/pin_verify_change_handler_bench.sv]
// self-checking bench of the secret-code handler, one task per scenario
// assumes the handler and terminal model are compiled with pin_pkg
`timescale 1ns/100ps
module pin_verify_change_handler_bench;
  import pin_pkg::*;

  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        nvErase = 1'b1;
  logic        busy, cmdValid, accessGranted;
  apdu_s       cmd;
  rsp_s        rsp;
  regreq_s     busReq = '0;
  logic [31:0] rdata, rv;
  logic [2:0]  accessIdx = 3'h0;
  logic [15:0] sw;
  int          fails = 0;
  int          num_checks = 0;

  always #2.5 mclk = ~mclk;

  pin_verify_change_handler u_pin_verify_change_handler (
    .mclk(mclk), .sys_rst(sys_rst), .nvErase(nvErase), .cmd(cmd), .cmdValid(cmdValid),
    .busy(busy), .rsp(rsp), .busReq(busReq), .rdata(rdata), .accessIdx(accessIdx),
    .accessGranted(accessGranted));
  pin_terminal u_pin_terminal (
    .mclk(mclk), .busy(busy), .rsp(rsp), .cmd(cmd), .cmdValid(cmdValid));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] ret(input logic [3:0] n);
    return SW_RETRY_BASE | {12'h000, n};
  endfunction
  task automatic cmdChk(input logic chg, input logic [7:0] p1, input logic [7:0] p2,
                        input logic lcp, input logic [7:0] lc, input logic [127:0] d,
                        input logic [15:0] exp);
    u_pin_terminal.send(chg, p1, p2, lcp, lc, d, sw);
    chk("status word", {16'h0000, sw}, {16'h0000, exp});
  endtask
  task automatic vfy(input logic [7:0] p2, input logic [63:0] c, input logic [15:0] exp);
    cmdChk(1'b0, P1_ZERO, p2, 1'b1, LC_VERIFY, {c, 64'h0000_0000_0000_0000}, exp);
  endtask
  task automatic qry(input logic [7:0] p2, input logic [15:0] exp);
    cmdChk(1'b0, P1_ZERO, p2, 1'b0, 8'h00, '0, exp);
  endtask
  task automatic chg(input logic [63:0] o, input logic [63:0] n, input logic [15:0] exp);
    cmdChk(1'b1, P1_ZERO, 8'h03, 1'b1, LC_CHANGE, {o, n}, exp);
  endtask
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    busReq.wr <= 1'b0;
  endtask
  task automatic regRd(input logic [7:0] a);
    @(posedge mclk);
    busReq <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge mclk);
    busReq.rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  task automatic acc(input logic [2:0] idx, input logic exp);
    @(posedge mclk);
    accessIdx <= idx;
    repeat (2) @(posedge mclk);
    #1;
    chk("access", {31'h0, accessGranted}, {31'h0, exp});
  endtask
  task automatic doReset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic tBlock();
    qry(8'h01, ret(4'h3));
    qry(8'h81, ret(4'h3));
    vfy(8'h01, 64'h0000_0000_0000_0001, ret(4'h2));
    vfy(8'h01, 64'h0000_0000_0000_0002, ret(4'h1));
    vfy(8'h01, 64'h0000_0000_0000_0003, ret(4'h0));
    vfy(8'h01, CODE_ERASED, SW_BLOCKED);
    cmdChk(1'b1, P1_ZERO, 8'h01, 1'b1, LC_CHANGE, '0, SW_BLOCKED);
    qry(8'h01, SW_BLOCKED);
    regRd(A_BLOCKED);
    chk("blocked flag", rv & 32'h0000_0001, 32'h0000_0001);
    acc(3'h0, 1'b0);
  endtask
  task automatic tVerify();
    vfy(8'h02, 64'h0000_0000_0000_0001, ret(4'h2));
    acc(3'h1, 1'b0);
    vfy(8'h02, CODE_ERASED, SW_OK);
    qry(8'h02, ret(4'h3));
    acc(3'h1, 1'b1);
  endtask
  task automatic tChange();
    chg(64'h0000_0000_0000_0005, 64'h0000_0000_0000_00AA, ret(4'h2));
    vfy(8'h03, CODE_ERASED, SW_OK);
    chg(CODE_ERASED, 64'hA5A5_0000_1111_2222, SW_OK);
    qry(8'h03, ret(4'h3));
    vfy(8'h03, 64'hA5A5_0000_1111_2222, SW_OK);
    vfy(8'h03, CODE_ERASED, ret(4'h2));
  endtask
  task automatic tFields();
    cmdChk(1'b0, 8'h01, 8'h04, 1'b1, LC_VERIFY, '1, SW_WRONG_P1P2);
    cmdChk(1'b0, P1_ZERO, 8'h24, 1'b1, LC_VERIFY, '1, SW_WRONG_P1P2);
    cmdChk(1'b0, P1_ZERO, 8'h00, 1'b1, LC_VERIFY, '1, SW_WRONG_P1P2);
    cmdChk(1'b0, P1_ZERO, 8'h04, 1'b1, 8'h07, '1, SW_WRONG_LEN);
    cmdChk(1'b1, P1_ZERO, 8'h04, 1'b0, 8'h00, '1, SW_WRONG_LEN);
    cmdChk(1'b1, P1_ZERO, 8'h04, 1'b1, LC_VERIFY, '1, SW_WRONG_LEN);
    vfy(8'h05, 64'h0000_0000_0000_0001, SW_NOT_FOUND);
    qry(8'h04, ret(4'h3));
  endtask
  task automatic tDisable();
    regWr(A_DISABLE, 32'h0000_0008);
    vfy(8'h04, 64'h0000_0000_0000_0001, SW_COND);
    chg(64'hA5A5_0000_1111_2222, CODE_ERASED, SW_OK);
    cmdChk(1'b1, P1_ZERO, 8'h04, 1'b1, LC_CHANGE, '0, SW_COND);
    qry(8'h04, ret(4'h3));
    acc(3'h3, 1'b1);
    regWr(A_DISABLE, 32'h0000_0000);
    acc(3'h3, 1'b0);
  endtask
  task automatic tPersist();
    vfy(8'h04, 64'h0000_0000_0000_0001, ret(4'h2));
    doReset();
    qry(8'h04, ret(4'h2));
    vfy(8'h04, 64'h0000_0000_0000_0001, ret(4'h1));
    regRd(A_RETRY);
    chk("retry counters", rv, 32'h0000_FF7C);
    regRd(8'h40);
    chk("unmapped read", rv, RDATA_RST);
  endtask
  task automatic tUnblock();
    regWr(A_CODE_HI, 32'hCAFE_0001);
    regWr(A_CODE_LO, 32'h1234_5678);
    regWr(A_UNBLOCK, 32'h0000_0000);
    vfy(8'h01, 64'hCAFE_0001_1234_5678, SW_OK);
    acc(3'h0, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100us;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    nvErase <= 1'b0;
    tBlock();
    tVerify();
    tChange();
    tFields();
    tDisable();
    tPersist();
    tUnblock();
    wrap_up();
  end
endmodule
